// ===== rtl/output_serializer_gearbox.sv
// Purpose: parallel core words to a serial line, 7:1, 8:1 or dual 4:1
// Assumes: ref_clk_i acts as the edge fast clock, one bit per edge
// Notes:   word tick stands in for the slow system clock
// Functional notes
// - each top-edge io cell serializes up to eight bits onto one line, or four onto each of two lines in split mode
// - gearbox runs as 7:1, single 8:1, or two independent 4:1 units
// - first pipeline stage captures the core word on the slow clock
// - second stage moves the captured word into fast-clock registers
// - third stage shifts bits out one by one onto the serial line
`include "gearbox_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module word_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_r [D];
  logic [W-1:0]  mem_nxt [D];
  logic [AW-1:0] wp_r, wp_nxt;
  logic [AW-1:0] rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  assign in_ready_o  = (cnt_r != (AW+1)'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    wp_nxt  = push ? ptr_inc(wp_r) : wp_r;
    rp_nxt  = pop ? ptr_inc(rp_r) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < D; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (push) begin
      mem_nxt[wp_r] = in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    mem_r <= mem_nxt;
  end
endmodule : word_fifo

module output_serializer_gearbox (
  input  wire logic                    ref_clk_i,
  input  wire logic                    nrst_i,
  input  wire gearbox_pkg::gear_mode_t mode_i,
  input  wire logic [`GB_WORD_W-1:0]   word_i,
  input  wire logic                    word_valid_i,
  output logic                         word_ready_o,
  output logic                         serial_o,
  output logic                         serial_second_o,
  output logic                         word_start_o
);
  import gearbox_pkg::*;

  logic                  rst_meta_r;
  logic                  rst_n_r;
  logic [`GB_WORD_W-1:0] fifo_data;
  logic                  fifo_valid;
  logic                  tick;
  logic [`GB_WORD_W-1:0] cap_r, cap_nxt;
  logic [`GB_WORD_W-1:0] xfer_r, xfer_nxt;
  logic [`GB_WORD_W-1:0] shift_r, shift_nxt;
  logic [`GB_CNT_W-1:0]  cnt_r, cnt_nxt;
  gear_mode_t            mode_r, mode_nxt;
  logic                  ser_r, ser_nxt;
  logic                  ser2_r, ser2_nxt;
  logic                  start_r, start_nxt;

  function automatic logic [`GB_CNT_W-1:0] last_bit(input gear_mode_t m);
    case (m)
      video_seven_to_one:        last_bit = `GB_LAST_7TO1;
      generic_eight_to_one_mode: last_bit = `GB_LAST_8TO1;
      generic_four_to_one_mode:  last_bit = `GB_LAST_4TO1;
      default:                   last_bit = `GB_LAST_8TO1;
    endcase
  endfunction : last_bit

  // split mode shifts each nibble on its own so the halves stay independent
  function automatic logic [`GB_WORD_W-1:0] shift_one(input gear_mode_t m,
                                                      input logic [`GB_WORD_W-1:0] s);
    shift_one = s >> 1;
    if (m == generic_four_to_one_mode) begin
      shift_one = (s >> 1) & `GB_SPLIT_MASK;
    end
  endfunction : shift_one

  // reset release through two flops
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  word_fifo #(
    .W (`GB_WORD_W),
    .D (`GB_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (ref_clk_i),
    .rst_n_i     (rst_n_r),
    .in_data_i   (word_i),
    .in_valid_i  (word_valid_i),
    .in_ready_o  (word_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (tick)
  );

  // word boundary: the slow-clock edge of the pipeline
  assign tick = (cnt_r == last_bit(mode_r));

  // bit counter and the mode latched at each word boundary
  always_comb begin
    cnt_nxt  = tick ? `GB_CNT_ZERO : cnt_r + 1'b1;
    mode_nxt = tick ? mode_i : mode_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cnt_r  <= `GB_CNT_ZERO;
      mode_r <= generic_eight_to_one_mode;
    end else begin
      cnt_r  <= cnt_nxt;
      mode_r <= mode_nxt;
    end
  end

  // three-stage pipeline: capture, transfer, shift
  always_comb begin
    cap_nxt   = cap_r;
    xfer_nxt  = xfer_r;
    shift_nxt = shift_one(mode_r, shift_r);
    if (tick) begin
      cap_nxt = `GB_WORD_ZERO;
      if (fifo_valid) begin
        cap_nxt = (mode_i == video_seven_to_one) ?
                  (fifo_data & `GB_LOW7_MASK) : fifo_data;
      end
      xfer_nxt  = cap_r;
      shift_nxt = xfer_r;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cap_r   <= `GB_WORD_ZERO;
      xfer_r  <= `GB_WORD_ZERO;
      shift_r <= `GB_WORD_ZERO;
    end else begin
      cap_r   <= cap_nxt;
      xfer_r  <= xfer_nxt;
      shift_r <= shift_nxt;
    end
  end

  // output flops follow the shift stage's next value
  always_comb begin
    ser_nxt  = shift_nxt[`GB_LANE1_BIT];
    ser2_nxt = 1'b0;
    if (mode_nxt == generic_four_to_one_mode) begin
      ser2_nxt = shift_nxt[`GB_LANE2_BIT];
    end
    start_nxt = tick;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ser_r   <= 1'b0;
      ser2_r  <= 1'b0;
      start_r <= 1'b0;
    end else begin
      ser_r   <= ser_nxt;
      ser2_r  <= ser2_nxt;
      start_r <= start_nxt;
    end
  end

  assign serial_o        = ser_r;
  assign serial_second_o = ser2_r;
  assign word_start_o    = start_r;
endmodule : output_serializer_gearbox

`default_nettype wire

// ===== rtl/gearbox_defines.svh
// Purpose: constants for the output serializer gearbox
// Assumes: included by its bare name
// Notes:   counts are last-bit indices of each serial word
`ifndef GEARBOX_DEFINES_SVH
`define GEARBOX_DEFINES_SVH
`define GB_WORD_W     8
`define GB_FIFO_DEPTH 4
`define GB_CNT_W      3
`define GB_LAST_7TO1  3'h6
`define GB_LAST_8TO1  3'h7
`define GB_LAST_4TO1  3'h3
`define GB_CNT_ZERO   3'h0
`define GB_WORD_ZERO  8'h00
`define GB_LOW7_MASK  8'h7f
`define GB_SPLIT_MASK 8'h77
`define GB_LANE1_BIT  0
`define GB_LANE2_BIT  4
`endif

// ===== rtl/gearbox_pkg.sv
// Purpose: types for the output serializer gearbox
// Assumes: nothing
// Notes:   mode selects one of the three gear ratios
package gearbox_pkg;
  typedef enum logic [1:0] {
    video_seven_to_one,
    generic_eight_to_one_mode,
    generic_four_to_one_mode
  } gear_mode_t;
endpackage : gearbox_pkg

// ===== test/core_src.sv
// Purpose: core-side word source
// Assumes: ready_i is not-full
// Notes:   bit 0 set so idle zeros stand apart
`timescale 1ns/100ps
`default_nettype none
module core_src (
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic       ready_i,
  output logic [7:0]      word_o,
  output logic            valid_o
);
  integer seed = 75415;
  integer r;
  initial valid_o = 1'b0;
  initial word_o = 8'h01;
  always @(posedge clk_i) begin
    if (!valid_o || ready_i) begin
      r = $random(seed);
      valid_o <= en_i && r[4];
      word_o  <= 8'(r) | 8'h01;
    end
  end
endmodule : core_src
`default_nettype wire

// ===== test/gearbox_chk.sv
// Purpose: port checker for the gearbox
// Assumes: bound to the top module
// Notes:   one clock domain
`timescale 1ns/100ps
`default_nettype none
module gearbox_chk (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire gearbox_pkg::gear_mode_t mode_i,
  input wire logic word_ready_o,
  input wire logic serial_o,
  input wire logic serial_second_o,
  input wire logic word_start_o
);
  default clocking @(posedge ref_clk_i); endclocking
  sequence s_quiet;
    !word_start_o [*3];
  endsequence
  sequence s_first_word;
    !word_start_o [*8] ##1 !word_start_o [*2] ##1 word_start_o;
  endsequence
  sequence s_no_split;
    (mode_i != gearbox_pkg::generic_four_to_one_mode) [*8] ##1
      (mode_i != gearbox_pkg::generic_four_to_one_mode);
  endsequence
  a_restart_phase: assert property (disable iff (!nrst_i) $rose(nrst_i) |-> s_first_word)
    else $error("first word boundary misplaced after reset");
  a_second_idle: assert property (disable iff (!nrst_i) s_no_split |=> !serial_second_o)
    else $error("second lane active outside split mode");
  a_reset_quiet: assert property (!nrst_i |-> !serial_o && !serial_second_o && !word_start_o)
    else $error("outputs not low in reset");
  a_reset_ready: assert property (!nrst_i |-> word_ready_o)
    else $error("fifo not ready in reset");
  a_restart_quiet: assert property (disable iff (!nrst_i) $rose(nrst_i) |-> s_quiet)
    else $error("start too soon after reset");
  a_start_gap: assert property (disable iff (!nrst_i) word_start_o |=> s_quiet)
    else $error("word period below four");
  a_ready_back: assert property (disable iff (!nrst_i) !word_ready_o |-> ##[1:8] word_ready_o)
    else $error("fifo stuck full");
endmodule : gearbox_chk
bind output_serializer_gearbox gearbox_chk i_gearbox_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .mode_i(mode_i),
  .word_ready_o(word_ready_o), .serial_o(serial_o), .serial_second_o(serial_second_o),
  .word_start_o(word_start_o));
`default_nettype wire

// ===== test/output_serializer_gearbox_tb.sv
// Purpose: self-checking gearbox bench
// Assumes: mode held per phase, pipeline drained between
// Notes:   all-zero words are idle fill
`timescale 1ns/100ps
`default_nettype none
module output_serializer_gearbox_tb;
  import gearbox_pkg::*;
  logic       ref_clk_i = 1'b0;
  logic       nrst_i = 1'b1;
  logic       en = 1'b0;
  logic       full_seen = 1'b0;
  logic       word_valid_i, word_ready_o, serial_o, serial_second_o, word_start_o;
  logic [7:0] word_i, rx;
  logic [7:0] q[$];
  gear_mode_t m = generic_eight_to_one_mode;
  int         fails = 0, total_checks = 0, k = 8, n;
  initial forever #5 ref_clk_i = ~ref_clk_i;
  core_src i_core_src (.clk_i(ref_clk_i), .en_i(en), .ready_i(word_ready_o),
    .word_o(word_i), .valid_o(word_valid_i));
  output_serializer_gearbox i_output_serializer_gearbox (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .mode_i(m), .word_i(word_i), .word_valid_i(word_valid_i),
    .word_ready_o(word_ready_o), .serial_o(serial_o), .serial_second_o(serial_second_o),
    .word_start_o(word_start_o));
  task check(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (e !== g) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : check
  task stop_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  always @(posedge ref_clk_i) begin
    n = (m == video_seven_to_one) ? 7 : (m == generic_eight_to_one_mode) ? 8 : 4;
    if (nrst_i && word_valid_i && word_ready_o)
      q.push_back((m == video_seven_to_one) ? (word_i & 8'h7f) : word_i);
    if (word_valid_i && !word_ready_o) full_seen = 1'b1;
    if (m != generic_four_to_one_mode) check("second", 8'h00, {7'h00, serial_second_o});
    if (word_start_o) begin
      rx = 8'h00;
      k = 0;
    end
    if (k < n) begin
      rx[k] = serial_o;
      if (m == generic_four_to_one_mode) rx[k+4] = serial_second_o;
      k++;
      if (k == n && rx !== 8'h00) begin
        check("word", (q.size() > 0) ? q[0] : 8'hxx, rx);
        if (q.size() > 0) void'(q.pop_front());
      end
    end
  end
  initial begin
    nrst_i <= 1'b0;
    repeat (12) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        nrst_i <= 1'b0;
        repeat (12) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
      end
      m <= gear_mode_t'(i);
      repeat (40) @(posedge ref_clk_i);
      q.delete();
      en <= 1'b1;
      repeat (300) @(posedge ref_clk_i);
      en <= 1'b0;
      repeat (90) @(posedge ref_clk_i);
      check("left", 8'h00, 8'(q.size()));
    end
    check("full", 8'h01, {7'h00, full_seen});
    stop_test();
  end
endmodule : output_serializer_gearbox_tb
`default_nettype wire
